// File: hw/bsc_params.svh
// Notes on behaviour
// - Each width bit picks 16-bit data at 0, 8-bit at 1; spaces other than upper default 16-bit.
// - Upper-space width bit takes writes only when the boot width was 8-bit.
// - Upper-space width comes from the boot pin; a 16-bit boot stays 16-bit.
// - High-byte write enable low only when high-byte enable and write are low.
// - Low-byte write enable low only when address bit zero and write are low.
// - Byte write enables sit inside a stable address for SRAM write timing.
// - Strobe mode drives a data strobe on the data-enable pin, bus valid.
// - In strobe mode the bus cycle waits until the ready input is seen.
// - Two DRAM banks at most: lower bank on lower space, upper on upper.
// - An enabled bank turns on column strobes and address multiplexing for accesses to its own space only.
// - Every refresh cycle lasts exactly seven clocks.
// - All control registers decode as 16-bit words in one 256-byte block.
// - A byte write to the block stores the whole 16-bit word.
// - Control registers sit at FEh, F6h, F4h, F2h, F0h and E6h.
// - DRAM row address is the full address; column swaps odd bits for even.
// - Refresh keeps the external address stable; internal address all ones.
`ifndef BSC_PARAMS_SVH
`define BSC_PARAMS_SVH

// ==========================================================
// Register block offsets and reset values
`define BSC_OFF_WDOG 8'he6
`define BSC_OFF_SYS 8'hf0
`define BSC_OFF_AUX 8'hf2
`define BSC_OFF_REL 8'hf4
`define BSC_OFF_RCFG 8'hf6
`define BSC_OFF_RELOC 8'hfe
`define BSC_RELOC_RESET 16'h20ff
`define BSC_RELOC_MEM_BIT 12
`define BSC_WORD_RESET 16'h0000

// ==========================================================
// Field positions
`define BSC_AUX_BITS 5
`define BSC_AUX_STRB 0
`define BSC_AUX_IO 1
`define BSC_AUX_OTHER 2
`define BSC_AUX_LOWER 3
`define BSC_AUX_UPPER 4
`define BSC_SYS_BANK0 0
`define BSC_SYS_BANK1 1

// ==========================================================
// Timing counts in clocks
`define BSC_REFRESH_CLOCKS 3'd7
`define BSC_REF_CAS_ON 3'd1
`define BSC_REF_RAS_ON 3'd2
`define BSC_REF_ALL_OFF 3'd6
`define BSC_DATA_MIN_CLOCKS 3'd3
`define BSC_BOOT_SETTLE 2'd2

`endif

// File: hw/bsc_pkg.sv
package bsc_pkg;

   // ==========================================================
   // Bus cycle states, Gray coded along the usual path.
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_addr = 3'b001,
      st_data = 3'b011,
      st_endc = 3'b010,
      st_refr = 3'b110
   } bsc_state_type;

   // ==========================================================
   // Column address: odd pins 1..17 carry the even address bits.
   function automatic logic [19:0] bsc_col_addr(input logic [19:0] a);
      logic [19:0] r;
      r = a;
      for (int i = 0; i < 9; i++) begin
         r[2*i+1] = a[2*i];
      end
      return r;
   endfunction

   // Offset compare inside the register block.
   function automatic logic bsc_off_is(input logic [7:0] a,
                                       input logic [7:0] off);
      return a[7:1] == off[7:1];
   endfunction

endpackage

// File: hw/bsc_cfg_if.sv
`timescale 1ns/100ps
`default_nettype none
interface bsc_cfg_if;
   logic wr;
   logic [15:0] wdata;
   logic [15:0] aux;
   modport host (output wr, output wdata, input aux);
   modport cfg (input wr, input wdata, output aux);
endinterface : bsc_cfg_if
`default_nettype wire

// File: hw/bsc_width_cfg.sv
`timescale 1ns/100ps
`default_nettype none
`include "bsc_params.svh"
module bsc_width_cfg
   import bsc_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Boot strap pin
   input wire logic i_boot_width_select_pin,
   // Register access
   bsc_cfg_if.cfg cfg
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic [1:0] settle;
      logic captured;
      logic boot8;
      logic [`BSC_AUX_BITS-1:0] aux;
   } bsc_cfg_state_type;

   bsc_cfg_state_type q;
   bsc_cfg_state_type n;

   // ==========================================================
   // The strap is caught after release, once the synchroniser settled.
   always_comb begin
      n = q;
      n.sync1 = i_boot_width_select_pin;
      n.sync2 = q.sync1;
      if (!q.captured) begin
         n.settle = q.settle + 2'd1;
         if (q.settle == `BSC_BOOT_SETTLE) begin
            n.captured = 1'b1;
            n.boot8 = q.sync2;
            n.aux[`BSC_AUX_UPPER] = q.sync2;
         end
      end else if (cfg.wr) begin
         n.aux[`BSC_AUX_STRB] = cfg.wdata[`BSC_AUX_STRB];
         n.aux[`BSC_AUX_IO] = cfg.wdata[`BSC_AUX_IO];
         n.aux[`BSC_AUX_OTHER] = cfg.wdata[`BSC_AUX_OTHER];
         n.aux[`BSC_AUX_LOWER] = cfg.wdata[`BSC_AUX_LOWER];
         if (q.boot8) begin
            n.aux[`BSC_AUX_UPPER] = cfg.wdata[`BSC_AUX_UPPER];
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else if (i_ce) begin
         q <= n;
      end
   end

   assign cfg.aux = {{(16-`BSC_AUX_BITS){1'b0}}, q.aux};

endmodule // bsc_width_cfg
`default_nettype wire

// File: hw/bsc_pin_io.sv
`timescale 1ns/100ps
`default_nettype none
`include "bsc_params.svh"
module bsc_pin_io
   import bsc_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Pins in
   input wire logic i_async_ready_in,
   input wire logic [15:0] i_data_in,
   // Registered strobes from the bus cycle
   input wire logic i_high_byte_enable_n,
   input wire logic i_wr_n,
   input wire logic i_a0,
   // Results
   output logic o_ready,
   output logic [15:0] o_data,
   output logic o_high_byte_write_enable_n,
   output logic o_low_byte_write_enable_n
);
   typedef struct packed {
      logic rdy1;
      logic rdy2;
      logic [15:0] d1;
      logic [15:0] d2;
   } bsc_sync_state_type;

   bsc_sync_state_type q;
   bsc_sync_state_type n;

   always_comb begin
      n = q;
      n.rdy1 = i_async_ready_in;
      n.rdy2 = q.rdy1;
      n.d1 = i_data_in;
      n.d2 = q.d1;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else if (i_ce) begin
         q <= n;
      end
   end

   assign o_ready = q.rdy2;
   assign o_data = q.d2;
   // Both inputs come from flops, so the enables carry no glitch.
   assign o_high_byte_write_enable_n = i_high_byte_enable_n | i_wr_n;
   assign o_low_byte_write_enable_n = i_a0 | i_wr_n;

endmodule // bsc_pin_io
`default_nettype wire

// File: hw/bsc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "bsc_params.svh"
module bsc_top
   import bsc_pkg::*;
#(
   // Value is arbitrary.
   parameter logic [15:0] RELEASE_LEVEL = 16'h0001
) (
   // Clock, reset, enable
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Processor request
   input wire logic i_req,
   input wire logic i_req_write,
   input wire logic i_req_word,
   input wire logic i_req_io,
   input wire logic i_req_upper,
   input wire logic i_req_lower,
   input wire logic [19:0] i_req_addr,
   input wire logic [15:0] i_req_wdata,
   output logic o_req_ready,
   output logic o_resp_valid,
   output logic [15:0] o_resp_rdata,
   // Refresh request and internal address
   input wire logic i_refresh_req,
   output logic [19:0] o_internal_addr,
   // Pins in
   input wire logic i_boot_width_select_pin,
   input wire logic i_async_ready_in,
   input wire logic [15:0] i_data_in,
   // Pins out
   output logic [19:0] o_addr,
   output logic [15:0] o_data_out,
   output logic o_data_oe,
   output logic o_rd_n,
   output logic o_wr_n,
   output logic o_high_byte_enable_n,
   output logic o_high_byte_write_enable_n,
   output logic o_low_byte_write_enable_n,
   output logic o_data_strobe_n,
   output logic o_row_strobe_bank0_n,
   output logic o_row_strobe_bank1_n,
   output logic o_upper_column_strobe_n,
   output logic o_lower_column_strobe_n,
   output logic o_cycle_width8
);
   typedef struct packed {
      bsc_state_type st;
      logic [19:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic write;
      logic word_pend;
      logic width8;
      logic dram;
      logic upper;
      logic strobe;
      logic [2:0] cnt;
      logic rd_n;
      logic wr_n;
      logic high_be_n;
      logic data_en_n;
      logic data_oe;
      logic row_strobe_bank0_n;
      logic row_strobe_bank1_n;
      logic upper_column_strobe_n;
      logic lower_column_strobe_n;
      logic col;
      logic done;
      logic [15:0] wdog;
      logic [15:0] sys;
      logic [15:0] rcfg;
      logic [15:0] reloc;
   } bsc_main_state_type;

   localparam bsc_main_state_type RESET_STATE = '{
      st: st_idle,
      addr: '0,
      wdata: '0,
      rdata: '0,
      write: 1'b0,
      word_pend: 1'b0,
      width8: 1'b0,
      dram: 1'b0,
      upper: 1'b0,
      strobe: 1'b0,
      cnt: '0,
      rd_n: 1'b1,
      wr_n: 1'b1,
      high_be_n: 1'b1,
      data_en_n: 1'b1,
      data_oe: 1'b0,
      row_strobe_bank0_n: 1'b1,
      row_strobe_bank1_n: 1'b1,
      upper_column_strobe_n: 1'b1,
      lower_column_strobe_n: 1'b1,
      col: 1'b0,
      done: 1'b0,
      wdog: `BSC_WORD_RESET,
      sys: `BSC_WORD_RESET,
      rcfg: `BSC_WORD_RESET,
      reloc: `BSC_RELOC_RESET
   };

   bsc_main_state_type q;
   bsc_main_state_type n;

   bsc_cfg_if cfg_bus ();

   logic ready_sync;
   logic [15:0] data_sync;
   logic [15:0] aux;
   logic bank_any;
   logic blk_hit;
   logic req_width8;
   logic req_dram;
   logic refresh_go;
   logic [7:0] off;
   logic [15:0] blk_rdata;

   // ==========================================================
   // Submodules
   bsc_width_cfg u_cfg (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_boot_width_select_pin(i_boot_width_select_pin),
      .cfg(cfg_bus.cfg)
   );

   bsc_pin_io u_pins (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_async_ready_in(i_async_ready_in),
      .i_data_in(i_data_in),
      .i_high_byte_enable_n(q.high_be_n),
      .i_wr_n(q.wr_n),
      .i_a0(q.addr[0]),
      .o_ready(ready_sync),
      .o_data(data_sync),
      .o_high_byte_write_enable_n(o_high_byte_write_enable_n),
      .o_low_byte_write_enable_n(o_low_byte_write_enable_n)
   );

   // ==========================================================
   // Request decode
   assign aux = cfg_bus.aux;
   assign off = i_req_addr[7:0];
   assign bank_any = q.sys[`BSC_SYS_BANK0] | q.sys[`BSC_SYS_BANK1];
   assign refresh_go = (q.st == st_idle) && i_refresh_req && bank_any;

   // The block answers either in memory or in I/O space, never both.
   always_comb begin
      if (q.reloc[`BSC_RELOC_MEM_BIT]) begin
         blk_hit = !i_req_io && (i_req_addr[19:8] == q.reloc[11:0]);
      end else begin
         blk_hit = i_req_io && (i_req_addr[15:8] == q.reloc[7:0]);
      end
   end

   // Width is read at cycle start only, so a write lands on later cycles.
   always_comb begin
      if (i_req_io) begin
         req_width8 = aux[`BSC_AUX_IO];
      end else if (i_req_upper) begin
         req_width8 = aux[`BSC_AUX_UPPER];
      end else if (i_req_lower) begin
         req_width8 = aux[`BSC_AUX_LOWER];
      end else begin
         req_width8 = aux[`BSC_AUX_OTHER];
      end
   end

   assign req_dram = !i_req_io &&
      ((i_req_lower && q.sys[`BSC_SYS_BANK0]) ||
       (i_req_upper && q.sys[`BSC_SYS_BANK1]));

   always_comb begin
      blk_rdata = '0;
      if (bsc_off_is(off, `BSC_OFF_WDOG)) begin
         blk_rdata = q.wdog;
      end else if (bsc_off_is(off, `BSC_OFF_SYS)) begin
         blk_rdata = q.sys;
      end else if (bsc_off_is(off, `BSC_OFF_AUX)) begin
         blk_rdata = aux;
      end else if (bsc_off_is(off, `BSC_OFF_REL)) begin
         blk_rdata = RELEASE_LEVEL;
      end else if (bsc_off_is(off, `BSC_OFF_RCFG)) begin
         blk_rdata = q.rcfg;
      end else if (bsc_off_is(off, `BSC_OFF_RELOC)) begin
         blk_rdata = q.reloc;
      end
   end

   assign cfg_bus.wr = i_req && (q.st == st_idle) && !refresh_go &&
      blk_hit && i_req_write && bsc_off_is(off, `BSC_OFF_AUX);
   assign cfg_bus.wdata = i_req_wdata;

   // ==========================================================
   // Bus cycle sequencer
   always_comb begin
      n = q;
      n.done = 1'b0;
      unique case (q.st)
         st_idle: begin
            n.col = 1'b0;
            if (refresh_go) begin
               n.st = st_refr;
               n.cnt = '0;
            end else if (i_req && blk_hit) begin
               n.done = 1'b1;
               if (i_req_write) begin
                  // Byte or word, the full word is stored.
                  if (bsc_off_is(off, `BSC_OFF_WDOG)) begin
                     n.wdog = i_req_wdata;
                  end
                  if (bsc_off_is(off, `BSC_OFF_SYS)) begin
                     n.sys = i_req_wdata;
                  end
                  if (bsc_off_is(off, `BSC_OFF_RCFG)) begin
                     n.rcfg = i_req_wdata;
                  end
                  if (bsc_off_is(off, `BSC_OFF_RELOC)) begin
                     n.reloc = i_req_wdata;
                  end
               end else begin
                  n.rdata = blk_rdata;
               end
            end else if (i_req) begin
               n.st = st_addr;
               n.addr = i_req_addr;
               n.write = i_req_write;
               n.width8 = req_width8;
               n.upper = i_req_upper;
               n.dram = req_dram;
               n.strobe = aux[`BSC_AUX_STRB];
               n.word_pend = i_req_word && req_width8 && !i_req_addr[0];
               n.high_be_n = req_width8 || !(i_req_word || i_req_addr[0]);
               if (req_width8 && i_req_addr[0]) begin
                  n.wdata = {i_req_wdata[15:8], i_req_wdata[15:8]};
               end else begin
                  n.wdata = i_req_wdata;
               end
               n.row_strobe_bank0_n = !(req_dram && i_req_lower);
               n.row_strobe_bank1_n = !(req_dram && i_req_upper);
            end
         end
         st_addr: begin
            n.st = st_data;
            n.cnt = '0;
            n.rd_n = q.write;
            n.wr_n = !q.write;
            n.data_en_n = 1'b0;
            n.data_oe = q.write;
            if (q.dram) begin
               n.col = 1'b1;
               n.upper_column_strobe_n = q.high_be_n;
               n.lower_column_strobe_n = q.addr[0];
            end
         end
         st_data: begin
            if (q.cnt != `BSC_DATA_MIN_CLOCKS) begin
               n.cnt = q.cnt + 3'd1;
            end
            // Data is read through the synchroniser, hence the floor.
            if ((q.cnt >= `BSC_DATA_MIN_CLOCKS - 3'd1) &&
                (!q.strobe || ready_sync)) begin
               n.st = st_endc;
               n.rd_n = 1'b1;
               n.wr_n = 1'b1;
               n.data_en_n = 1'b1;
               n.upper_column_strobe_n = 1'b1;
               n.lower_column_strobe_n = 1'b1;
               n.row_strobe_bank0_n = 1'b1;
               n.row_strobe_bank1_n = 1'b1;
               if (!q.write) begin
                  if (!q.width8) begin
                     n.rdata = data_sync;
                  end else if (q.addr[0]) begin
                     n.rdata[15:8] = data_sync[7:0];
                  end else begin
                     n.rdata[7:0] = data_sync[7:0];
                  end
               end
            end
         end
         st_endc: begin
            n.data_oe = 1'b0;
            n.col = 1'b0;
            if (q.word_pend) begin
               n.word_pend = 1'b0;
               n.st = st_addr;
               n.addr = q.addr + 20'h00001;
               n.wdata = {q.wdata[15:8], q.wdata[15:8]};
               n.row_strobe_bank0_n = !(q.dram && !q.upper);
               n.row_strobe_bank1_n = !(q.dram && q.upper);
            end else begin
               n.st = st_idle;
               n.done = 1'b1;
            end
         end
         st_refr: begin
            // Column before row; the address pins keep their last value.
            n.cnt = q.cnt + 3'd1;
            n.upper_column_strobe_n = !(q.cnt >= `BSC_REF_CAS_ON - 3'd1 &&
                         q.cnt < `BSC_REF_ALL_OFF - 3'd1);
            n.lower_column_strobe_n = n.upper_column_strobe_n;
            n.row_strobe_bank0_n = !(q.sys[`BSC_SYS_BANK0] &&
                         q.cnt >= `BSC_REF_RAS_ON - 3'd1 &&
                         q.cnt < `BSC_REF_ALL_OFF - 3'd1);
            n.row_strobe_bank1_n = !(q.sys[`BSC_SYS_BANK1] &&
                         q.cnt >= `BSC_REF_RAS_ON - 3'd1 &&
                         q.cnt < `BSC_REF_ALL_OFF - 3'd1);
            if (q.cnt == `BSC_REFRESH_CLOCKS - 3'd1) begin
               n.st = st_idle;
               n.cnt = '0;
            end
         end
         default: begin
            n = RESET_STATE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= RESET_STATE;
      end else if (i_ce) begin
         q <= n;
      end
   end

   // ==========================================================
   // Outputs
   assign o_req_ready = (q.st == st_idle) && !refresh_go;
   assign o_resp_valid = q.done;
   assign o_resp_rdata = q.rdata;
   assign o_internal_addr = (q.st == st_refr) ? {20{1'b1}} : q.addr;
   assign o_addr = q.col ? bsc_col_addr(q.addr) : q.addr;
   assign o_data_out = q.wdata;
   assign o_data_oe = q.data_oe;
   assign o_rd_n = q.rd_n;
   assign o_wr_n = q.wr_n;
   assign o_high_byte_enable_n = q.high_be_n;
   assign o_data_strobe_n = q.data_en_n;
   assign o_row_strobe_bank0_n = q.row_strobe_bank0_n;
   assign o_row_strobe_bank1_n = q.row_strobe_bank1_n;
   assign o_upper_column_strobe_n = q.upper_column_strobe_n;
   assign o_lower_column_strobe_n = q.lower_column_strobe_n;
   assign o_cycle_width8 = q.width8;

endmodule // bsc_top
`default_nettype wire

// File: bench/bsc_top_props.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Pin timing checks.
module bsc_top_props (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [19:0] o_addr,
   input wire logic [19:0] o_internal_addr,
   input wire logic o_wr_n,
   input wire logic o_high_byte_enable_n,
   input wire logic o_high_byte_write_enable_n,
   input wire logic o_low_byte_write_enable_n,
   input wire logic o_data_strobe_n,
   input wire logic o_row_strobe_bank0_n,
   input wire logic o_upper_column_strobe_n,
   input wire logic o_lower_column_strobe_n,
   input wire logic o_resp_valid,
   input wire logic o_data_oe
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   logic rf;
   logic cas;
   // The internal address is all ones during refresh, and also after a cycle to FFFFFh.
   assign rf = o_internal_addr == 20'hfffff;
   assign cas = !o_upper_column_strobe_n || !o_lower_column_strobe_n;
   property p_whb;
      o_high_byte_write_enable_n == (o_high_byte_enable_n | o_wr_n);
   endproperty
   a_whb: assert property (p_whb) else $error("high wr enable");
   property p_wlb;
      o_low_byte_write_enable_n == (o_addr[0] | o_wr_n);
   endproperty
   a_wlb: assert property (p_wlb) else $error("low wr enable");
   property p_wstab;
      !o_wr_n && $past(!o_wr_n) |-> $stable(o_addr);
   endproperty
   a_wstab: assert property (p_wstab) else $error("addr moved");
   property p_dstab;
      !o_data_strobe_n && $past(!o_data_strobe_n) |-> $stable(o_addr);
   endproperty
   a_dstab: assert property (p_dstab) else $error("strobe addr");
   property p_oe;
      !o_data_strobe_n && !o_wr_n |-> o_data_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("data not driven");
   property p_rlen;
      $rose(rf) |-> rf [*7] ##1 !rf;
   endproperty
   a_rlen: assert property (p_rlen) else $error("refresh len");
   property p_raddr;
      rf && $past(rf) |-> $stable(o_addr);
   endproperty
   a_raddr: assert property (p_raddr) else $error("refresh addr");
   property p_cbr;
      $fell(o_row_strobe_bank0_n) && rf |-> cas;
   endproperty
   a_cbr: assert property (p_cbr) else $error("column strobe");
   property p_row;
      $fell(o_row_strobe_bank0_n) && !rf |-> o_addr == o_internal_addr;
   endproperty
   a_row: assert property (p_row) else $error("row addr");
   property p_col;
      cas && !rf |-> o_addr[1] == o_internal_addr[0]
         && o_addr[17] == o_internal_addr[16];
   endproperty
   a_col: assert property (p_col) else $error("column addr");
   c_ref: cover property ($rose(rf));
   c_wr: cover property ($fell(o_wr_n));
   c_ds: cover property ($fell(o_data_strobe_n) && o_wr_n);
   c_resp: cover property (o_resp_valid);
endmodule // bsc_top_props
bind bsc_top bsc_top_props u_props (.i_clk_sys, .i_rst_n, .o_addr,
   .o_internal_addr, .o_wr_n, .o_high_byte_enable_n,
   .o_high_byte_write_enable_n, .o_low_byte_write_enable_n,
   .o_data_strobe_n, .o_row_strobe_bank0_n, .o_upper_column_strobe_n,
   .o_lower_column_strobe_n, .o_resp_valid, .o_data_oe);
`default_nettype wire

// File: bench/bsc_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Word memory and strobe peripheral.
module bsc_mem_model (
   input wire logic i_clk_sys,
   input wire logic [19:0] i_addr,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic i_whb_n,
   input wire logic i_wlb_n,
   input wire logic i_ds_n,
   input wire logic [15:0] i_wdata,
   input wire logic [3:0] i_dly,
   output logic [15:0] o_rdata,
   output logic o_ready
);
   logic [15:0] mem [256];
   logic [15:0] last = 16'h5a5a;
   logic [3:0] cnt = 4'h0;
   logic [7:0] ix;
   assign ix = i_addr[8:1];
   // Released pins toggle so a stale value never looks valid.
   assign o_rdata = !i_rd_n ? mem[ix] : ~last;
   always @(posedge i_clk_sys) begin
      last <= o_rdata;
      if (!i_wr_n && !i_whb_n) begin
         mem[ix][15:8] <= i_wdata[15:8];
      end
      if (!i_wr_n && !i_wlb_n) begin
         mem[ix][7:0] <= i_wdata[7:0];
      end
      cnt <= i_ds_n ? 4'h0 : cnt + 4'h1;
      o_ready <= !i_ds_n && cnt >= i_dly;
   end
endmodule // bsc_mem_model
`default_nettype wire

// File: bench/bsc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n,e,g) begin n_checks++; if ((g) !== (e)) begin failures++; \
$display("wrong value %s exp %h got %h", n, e, g); end end
module bsc_top_tb;
   logic clk = 0, rst_n = 0, req = 0, rw = 0, wd = 0, io = 0, up = 0;
   logic lo = 0, refr = 0, boot = 0, ce = 1, rdy, ready, vld, rd_n, wr_n;
   logic high_byte_write_enable, low_byte_write_enable, ds_n, row_strobe_bank0, row_strobe_bank1, w8;
   logic [19:0] addr = 20'h0, ia, pa, a;
   logic [15:0] wdata = 16'h0, din, dout, rdat, q, v;
   logic [3:0] dly = 4'h1;
   logic [7:0] offs [4] = '{8'he6, 8'hf0, 8'hf6, 8'hf4};
   int failures = 0, n_checks = 0, cyc = 0, lat, l16, n0, n1;
   bsc_top #(.RELEASE_LEVEL(16'h00a5)) uut (.i_clk_sys(clk),
      .i_rst_n(rst_n), .i_ce(ce), .i_req(req), .i_req_write(rw),
      .i_req_word(wd), .i_req_io(io), .i_req_upper(up),
      .i_req_lower(lo), .i_req_addr(addr), .i_req_wdata(wdata),
      .o_req_ready(ready), .o_resp_valid(vld), .o_resp_rdata(rdat),
      .i_refresh_req(refr), .o_internal_addr(ia),
      .i_boot_width_select_pin(boot), .i_async_ready_in(rdy),
      .i_data_in(din), .o_addr(pa), .o_data_out(dout), .o_data_oe(),
      .o_rd_n(rd_n), .o_wr_n(wr_n), .o_high_byte_enable_n(),
      .o_high_byte_write_enable_n(high_byte_write_enable), .o_low_byte_write_enable_n(low_byte_write_enable),
      .o_data_strobe_n(ds_n), .o_row_strobe_bank0_n(row_strobe_bank0),
      .o_row_strobe_bank1_n(row_strobe_bank1), .o_upper_column_strobe_n(),
      .o_lower_column_strobe_n(), .o_cycle_width8(w8));
   bsc_mem_model u_mem (.i_clk_sys(clk), .i_addr(pa), .i_rd_n(rd_n),
      .i_wr_n(wr_n), .i_whb_n(high_byte_write_enable), .i_wlb_n(low_byte_write_enable), .i_ds_n(ds_n),
      .i_wdata(dout), .i_dly(dly), .o_rdata(din), .o_ready(rdy));
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         wrap_up;
      end
   end
   // ==========
   // Bus tasks.
   task automatic wrap_up;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic xf(input logic w, b, i, u, l, input logic [19:0] ad,
                     input logic [15:0] d);
      @(posedge clk);
      req <= 1;
      rw <= w;
      wd <= b;
      io <= i;
      up <= u;
      lo <= l;
      addr <= ad;
      wdata <= d;
      @(negedge clk);
      while (ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      req <= 0;
      lat = 0;
      do begin
         @(negedge clk);
         lat++;
      end while (vld !== 1'b1 && lat < 60);
      q = rdat;
      // A transfer that never answers ends the run as a failure.
      if (vld !== 1'b1) begin
         failures++;
         wrap_up;
      end
   endtask
   task automatic wreg(input logic [7:0] o, input logic [15:0] d);
      xf(1, 0, 1, 0, 0, {12'h0ff, o}, d);
   endtask
   task automatic rreg(input logic [7:0] o);
      xf(0, 1, 1, 0, 0, {12'h0ff, o}, 16'h0);
   endtask
   task automatic do_reset(input logic bp);
      @(posedge clk);
      rst_n <= 0;
      boot <= bp;
      repeat (8) @(posedge clk);
      rst_n <= 1;
      repeat (5) @(posedge clk);
   endtask
   // ==========
   // Scenarios.
   initial begin
      v = 16'($urandom(37688));
      do_reset(1'b0);
      rreg(8'hfe); `CHK("reloc", 16'h20ff, q)
      rreg(8'hf4); `CHK("release", 16'h00a5, q)
      rreg(8'hf2); `CHK("aux", 16'h0000, q)
      rreg(8'hea); `CHK("unmapped", 16'h0000, q)
      foreach (offs[i]) begin
         v = 16'($urandom);
         wreg(offs[i], v);
         rreg(offs[i]);
         `CHK("word", (offs[i] == 8'hf4) ? 16'h00a5 : v, q)
      end
      wreg(8'hf0, 16'h0);
      wreg(8'hf2, 16'h001f);
      rreg(8'hf2); `CHK("aux boot16", 16'h000f, q)
      wreg(8'hf2, 16'h0);
      $display("registers done");
      repeat (20) begin
         a = 20'($urandom);
         a[0] = 0;
         v = 16'($urandom);
         xf(1, 1, 0, a[5], 0, a, v);
         xf(0, 1, 0, a[5], 0, a, 16'h0); `CHK("mem", v, q)
         `CHK("width", 1'b0, w8)
      end
      l16 = lat;
      xf(1, 0, 0, 0, 0, a | 20'h1, {~v[7:0], 8'h00});
      xf(0, 1, 0, 0, 0, a, 16'h0); `CHK("lane", {~v[7:0], v[7:0]}, q)
      $display("random done");
      wreg(8'hf2, 16'h000a);
      xf(0, 1, 0, 0, 1, a, 16'h0); `CHK("w8", 1'b1, w8)
      `CHK("two cycles", l16 + 5, lat)
      xf(0, 1, 0, 0, 0, a, 16'h0); `CHK("other", 1'b0, w8)
      xf(0, 1, 1, 0, 0, 20'h00100, 16'h0); `CHK("io", 1'b1, w8)
      wreg(8'hf2, 16'h0001);
      dly <= 4'h6;
      v = 16'($urandom);
      xf(1, 1, 0, 0, 0, a, v);
      xf(0, 1, 0, 0, 0, a, 16'h0); `CHK("strobe", v, q)
      `CHK("ready wait", 1'b1, lat > l16)
      wreg(8'hf2, 16'h0);
      // Three frozen edges inside the data phase stretch the cycle by three.
      fork
         xf(0, 1, 0, 0, 0, a, 16'h0);
         begin
            repeat (3) @(posedge clk);
            ce <= 0;
            repeat (3) @(posedge clk);
            ce <= 1;
         end
      join
      `CHK("freeze", l16 + 3, lat)
      $display("width done");
      wreg(8'hf0, 16'h0001);
      xf(1, 1, 0, 0, 1, a, ~v);
      xf(0, 1, 0, 0, 1, a, 16'h0); `CHK("dram", ~v, q)
      for (int c = 0; c < 4; c++) begin
         wreg(8'hf0, c[15:0]);
         @(posedge clk);
         refr <= 1;
         @(posedge clk);
         refr <= 0;
         n0 = 0;
         n1 = 0;
         repeat (12) begin
            @(negedge clk);
            n0 += int'(row_strobe_bank0 === 1'b0);
            n1 += int'(row_strobe_bank1 === 1'b0);
         end
         `CHK("bank0", c[0], n0 > 0)
         `CHK("bank1", c[1], n1 > 0)
      end
      $display("dram done");
      do_reset(1'b1);
      rreg(8'hf2); `CHK("aux boot8", 16'h0010, q)
      wreg(8'hf2, 16'h0);
      rreg(8'hf2); `CHK("upper write", 16'h0000, q)
      $display("boot done");
      wrap_up;
   end
endmodule // bsc_top_tb
`default_nettype wire
